//--- spismp_core.sv
`timescale 1ns/100ps

// How it works
// - Modes 000/001/010 run master with clock at system rate over 4, 16, 64.
// - Mode 011 clocks master from sub clock; 100 at half timer-match rate.
// - Mode 101 is slave, 110 is I2C; 111 runs no SPI at all.
// - As slave, no own clock; shifting follows external master clock edges only.
// - Master starts every transfer and drives clock; slave never starts one.
// - Enable low releases all serial pins and stops the logic.
// - Raising enable leaves all control register contents untouched.
// - Select-pin enable high uses select line; low leaves the pin floating.
// - Only one select pin exists, so one slave directly.
// - Transmit and receive bytes both pass through the one data register.
// - Data register is shared with I2C and reset loads it with DATA_RST (00h).
// - Slave deselected mid-byte sets incomplete flag and transfer-done flag.
// - Incomplete event raises the module event request.
// - Software setting incomplete flag never sets transfer-done flag.
// - Incomplete flag is set by hardware only in SPI slave mode.
// - Bit 4 of mode control reads as zero.
// - Bit order and active clock edge are both selectable.
// - Polarity bit 0 idles clock high, 1 idles clock low.
// - Edge select with polarity picks rising or falling capture edge.
// - Order bit 1 shifts MSB first, 0 LSB first.
// - Data write during transfer is dropped and sets write-collision flag.
module spismp_core (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Register port
  input wire logic [1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Master clock sources
  input wire logic sub_clk_i,
  input wire logic timer_match_i,
  // Serial clock pin
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe_o,
  // Serial data pins
  input wire logic sdi_i,
  output logic sdo_o,
  output logic sdo_oe_o,
  // Slave select pin
  input wire logic scs_n_i,
  output logic scs_n_o,
  output logic scs_oe_o,
  // Transfer done or incomplete event
  output logic spi_event_o
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_q;
  logic rst_n;

  // Two-stage release of the asynchronous reset
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end

  assign rst_n = rst_q[1];

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] pins_s;
  logic sck_s;
  logic sdi_s;
  logic scs_s;
  logic sub_s;

  spismp_sync #(
    .WIDTH(4),
    .RST_VAL(4'h2)
  ) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .async_i({sub_clk_i, sdi_i, scs_n_i, sck_i}),
    .sync_o(pins_s)
  );

  assign sck_s = pins_s[0];
  assign scs_s = pins_s[1];
  assign sdi_s = pins_s[2];
  assign sub_s = pins_s[3];

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    spismp_pkg::spismp_mode_t mode;
    logic [1:0] deb;
    logic en;
    logic icf;
    logic [1:0] spare;
    logic clock_idle_polarity;
    logic capture_edge_select;
    logic bit_order_select;
    logic select_pin_enable;
    logic write_collision_flag;
    logic transfer_done_flag;
    logic [7:0] sh;
    logic samp;
    logic busy;
    logic [3:0] ecnt;
    logic sck_q;
    logic mev;
    logic [5:0] div;
    logic sub_d;
    logic scs_d;
    logic sck_d;
    logic [7:0] rdata;
    logic evt;
  } spismp_state_t;

  spismp_state_t s;
  spismp_state_t next_s;

  // Shift one bit in at the far end from the outgoing bit
  function automatic logic [7:0] spismp_shift(input logic [7:0] cur, input logic b,
                                             input logic msb_first);
    spismp_shift = msb_first ? {cur[6:0], b} : {b, cur[7:1]};
  endfunction : spismp_shift

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic is_master;
  logic is_slave;
  logic sel_ok;
  logic in_xfer;
  logic tick;
  logic edge_ev;
  logic new_sck;
  logic leading;
  logic sample_ev;
  logic fin;
  logic early_end;
  logic wr_data;

  // Mode decode and slave selection
  always_comb begin
    is_master = (s.mode <= spismp_pkg::SPISMP_M_TIMER);
    is_slave = (s.mode == spismp_pkg::SPISMP_SLAVE);
    sel_ok = !s.select_pin_enable || !scs_s;
    in_xfer = s.busy || (s.ecnt != 4'h0);
    wr_data = wr_i && (addr_i == spismp_pkg::ADDR_DATA);
  end

  // Master bit-rate tick
  always_comb begin
    tick = 1'b0;
    unique case (s.mode)
      spismp_pkg::SPISMP_M_DIV4: tick = (s.div == spismp_pkg::HALF_DIV4 - 6'h1);
      spismp_pkg::SPISMP_M_DIV16: tick = (s.div == spismp_pkg::HALF_DIV16 - 6'h1);
      spismp_pkg::SPISMP_M_DIV64: tick = (s.div == spismp_pkg::HALF_DIV64 - 6'h1);
      spismp_pkg::SPISMP_M_SUB: tick = (sub_s != s.sub_d);
      spismp_pkg::SPISMP_M_TIMER: tick = timer_match_i;
      spismp_pkg::SPISMP_SLAVE, spismp_pkg::SPISMP_I2C,
      spismp_pkg::SPISMP_UNUSED: tick = 1'b0;
    endcase
  end

  // Clock edges of the current transfer and their meaning
  always_comb begin
    if (is_master) begin
      edge_ev = s.en && s.mev;
      new_sck = s.sck_q;
    end else begin
      edge_ev = s.en && is_slave && sel_ok && (sck_s != s.sck_d);
      new_sck = sck_s;
    end
    leading = (new_sck == s.clock_idle_polarity);
    sample_ev = edge_ev && (leading == s.capture_edge_select);
    fin = edge_ev && (s.ecnt == spismp_pkg::LAST_EDGE);
    early_end = s.en && is_slave && s.select_pin_enable && scs_s && !s.scs_d
                && (s.ecnt != 4'h0);
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.evt = 1'b0;
    next_s.sub_d = sub_s;
    next_s.scs_d = scs_s;
    next_s.sck_d = sck_s;
    next_s.div = (s.busy && !tick) ? s.div + 6'h1 : 6'h0;

    // Register writes; hardware sets below win over clears
    if (wr_i) begin
      unique case (addr_i)
        spismp_pkg::ADDR_MODE: begin
          next_s.mode = spismp_pkg::spismp_mode_t'(wdata_i[spismp_pkg::MODE_SEL_LSB +: 3]);
          next_s.deb = wdata_i[spismp_pkg::MODE_DEB_LSB +: 2];
          next_s.en = wdata_i[spismp_pkg::MODE_EN_BIT];
          next_s.icf = wdata_i[spismp_pkg::MODE_ICF_BIT];
        end
        spismp_pkg::ADDR_CFG: begin
          next_s.spare = wdata_i[spismp_pkg::CFG_SPARE_LSB +: 2];
          next_s.clock_idle_polarity = wdata_i[spismp_pkg::CFG_POL_BIT];
          next_s.capture_edge_select = wdata_i[spismp_pkg::CFG_EDGE_BIT];
          next_s.bit_order_select = wdata_i[spismp_pkg::CFG_ORDER_BIT];
          next_s.select_pin_enable = wdata_i[spismp_pkg::CFG_SELECT_PIN_ENABLE_BIT];
          next_s.write_collision_flag = wdata_i[spismp_pkg::CFG_WRITE_COLLISION_FLAG_BIT];
          next_s.transfer_done_flag = wdata_i[spismp_pkg::CFG_TRF_BIT];
        end
        spismp_pkg::ADDR_DATA: begin
          if (in_xfer) begin
            next_s.write_collision_flag = 1'b1;
          end else begin
            next_s.sh = wdata_i;
            if (s.en && is_master) begin
              next_s.busy = 1'b1;
              next_s.ecnt = 4'h0;
              next_s.sck_q = ~s.clock_idle_polarity;
            end
          end
        end
        default: begin
        end
      endcase
    end

    // Master clock toggles now; data step a cycle later, as received bits lag two flops
    next_s.mev = s.en && s.busy && is_master && tick && !fin;
    next_s.sck_q = next_s.mev ? ~s.sck_q : next_s.sck_q;
    // Serial clock edge: capture or launch
    if (edge_ev) begin
      if (sample_ev && !fin) begin
        next_s.samp = sdi_s;
      end else if (sample_ev) begin
        next_s.sh = spismp_shift(s.sh, sdi_s, s.bit_order_select);
      end else if (s.ecnt != 4'h0) begin
        next_s.sh = spismp_shift(s.sh, s.samp, s.bit_order_select);
      end
      next_s.ecnt = s.ecnt + 4'h1;
    end

    // Eight bits shifted both ways
    if (fin) begin
      next_s.transfer_done_flag = 1'b1;
      next_s.busy = 1'b0;
      next_s.ecnt = 4'h0;
      next_s.evt = 1'b1;
    end

    // Slave abandoned or deselected
    if (early_end) begin
      next_s.icf = 1'b1;
      next_s.transfer_done_flag = 1'b1;
      next_s.evt = 1'b1;
    end
    if (is_slave && !sel_ok) begin
      next_s.ecnt = 4'h0;
    end

    // Disabled or not in a master mode: no master transfer runs
    if (!s.en || !is_master) begin
      next_s.busy = 1'b0;
    end
    next_s.sck_q = next_s.busy ? next_s.sck_q : ~next_s.clock_idle_polarity;
    if (!s.en) begin
      next_s.ecnt = 4'h0;
    end

    // Read data, valid in the cycle after the strobe
    next_s.rdata = 8'h00;
    if (rd_i) begin
      unique case (addr_i)
        spismp_pkg::ADDR_MODE: next_s.rdata = {s.mode, 1'b0, s.deb, s.en, s.icf};
        spismp_pkg::ADDR_CFG: next_s.rdata = {s.spare, s.clock_idle_polarity, s.capture_edge_select, s.bit_order_select,
                                              s.select_pin_enable, s.write_collision_flag, s.transfer_done_flag};
        spismp_pkg::ADDR_DATA: next_s.rdata = s.sh;
        default: next_s.rdata = 8'h00;
      endcase
    end
  end

  // State register; data register loads DATA_RST (00h) at reset
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.mode <= spismp_pkg::spismp_mode_t'(spismp_pkg::MODE_SEL_RST);
      s.spare <= spismp_pkg::CFG_RST[7:6];
      s.sh <= spismp_pkg::DATA_RST;
      s.sck_q <= 1'b1;
      s.scs_d <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Pin drive follows enable, mode and select enable
  assign sck_o = s.sck_q;
  assign sck_oe_o = s.en && is_master;
  assign sdo_o = s.bit_order_select ? s.sh[7] : s.sh[0];
  assign sdo_oe_o = s.en && (is_master || (is_slave && sel_ok));
  assign scs_n_o = !s.busy;
  assign scs_oe_o = s.en && s.select_pin_enable && is_master;
  assign rdata_o = s.rdata;
  assign spi_event_o = s.evt;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence seq_start;
    wr_data && !in_xfer && s.en && is_master;
  endsequence

  sequence seq_idle_clock;
    s.busy && (sck_o == ~s.clock_idle_polarity);
  endsequence

  a_start_busy: assert property (@(posedge clk_i) disable iff (!rst_n)
    seq_start |=> seq_idle_clock)
    else $error("master write did not start a transfer");

  a_fast_rate: assert property (@(posedge clk_i) disable iff (!rst_n)
    (s.busy && s.mode == spismp_pkg::SPISMP_M_DIV4 && tick && !wr_i) |=> !tick ##1 tick)
    else $error("divide-by-four clock tick spacing wrong");

  a_idle_level: assert property (@(posedge clk_i) disable iff (!rst_n)
    (s.en && is_master && !s.busy && $stable(s.clock_idle_polarity)) |-> (sck_o == ~s.clock_idle_polarity))
    else $error("serial clock not at idle level");

  a_slave_noclk: assert property (@(posedge clk_i) disable iff (!rst_n)
    (is_slave || !s.en) |-> !sck_oe_o && !s.busy)
    else $error("clock driven outside master operation");

  a_disable_pins: assert property (@(posedge clk_i) disable iff (!rst_n)
    !s.en |-> !(sck_oe_o || sdo_oe_o || scs_oe_o))
    else $error("pins driven while module disabled");

  a_incomplete_both: assert property (@(posedge clk_i) disable iff (!rst_n)
    early_end |=> s.icf && s.transfer_done_flag && spi_event_o)
    else $error("early deselect did not set both flags");

  a_sw_icf_only: assert property (@(posedge clk_i) disable iff (!rst_n)
    (wr_i && addr_i == spismp_pkg::ADDR_MODE && !s.transfer_done_flag && !fin && !early_end)
    |=> !s.transfer_done_flag)
    else $error("software incomplete write set transfer-done");

  a_collision_flag: assert property (@(posedge clk_i) disable iff (!rst_n)
    (wr_data && in_xfer) |=> s.write_collision_flag)
    else $error("collision flag not set");

  a_bit4_zero: assert property (@(posedge clk_i) disable iff (!rst_n)
    (rd_i && addr_i == spismp_pkg::ADDR_MODE) |=> (rdata_o[4] == 1'b0))
    else $error("unimplemented bit read as one");

  a_eight_bits: assert property (@(posedge clk_i) disable iff (!rst_n)
    $rose(s.transfer_done_flag) && !$past(early_end) && !$past(wr_i) |-> $past(s.ecnt) == 4'hF)
    else $error("transfer ended before sixteen clock edges");

endmodule : spismp_core

//--- spismp_peer.sv
`timescale 1ns/100ps

module spismp_peer (
  // Clock for sampling the data line
  input wire logic clk_i,
  // Serial pins
  input wire logic sck_i,
  input wire logic sdo_i,
  input wire logic scs_n_i,
  output logic sdi_o,
  // Settings and bytes
  input wire logic [2:0] ctl_i,
  input wire logic [7:0] tx_i,
  output logic [7:0] rx_o
);
  logic [3:0] caps = 4'h0;
  logic q = 1'b0;
  logic sdo_prev = 1'b0;
  logic cap_rise;

  // Capture on rising edge when polarity equals edge select
  assign cap_rise = (ctl_i[2] == ctl_i[1]);
  // Released line shows the inverse of the last bit
  assign sdi_o = scs_n_i ? ~q : q;

  // Bit n of the outgoing byte in the chosen order
  function automatic logic pick(input logic [3:0] n);
    return ctl_i[0] ? tx_i[7 - n[2:0]] : tx_i[n[2:0]];
  endfunction : pick

  // Data line value half a cycle before any clock edge
  always @(negedge clk_i) begin
    sdo_prev <= sdo_i;
  end

  // Select low restarts the byte; never starts anything itself
  always @(negedge scs_n_i) begin
    caps = 4'h0;
    q = pick(4'h0);
  end

  // Shift only on the master's clock
  always @(sck_i) begin
    if (!scs_n_i) begin
      if (sck_i == cap_rise) begin
        rx_o = ctl_i[0] ? {rx_o[6:0], sdo_prev} : {sdo_prev, rx_o[7:1]};
        caps = caps + 4'h1;
      end else begin
        q = pick(caps);
      end
    end
  end
endmodule : spismp_peer

//--- spismp_pkg.sv
package spismp_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [1:0] ADDR_MODE = 2'h0; // serial_mode_control
  localparam logic [1:0] ADDR_CFG = 2'h1;  // serial_config_flags
  localparam logic [1:0] ADDR_DATA = 2'h2; // serial_shift_data

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int MODE_SEL_LSB = 5;
  localparam int MODE_DEB_LSB = 2;
  localparam int MODE_EN_BIT = 1;
  localparam int MODE_ICF_BIT = 0;
  localparam int CFG_SPARE_LSB = 6;
  localparam int CFG_POL_BIT = 5;
  localparam int CFG_EDGE_BIT = 4;
  localparam int CFG_ORDER_BIT = 3;
  localparam int CFG_SELECT_PIN_ENABLE_BIT = 2;
  localparam int CFG_WRITE_COLLISION_FLAG_BIT = 1;
  localparam int CFG_TRF_BIT = 0;

  // ----------------------------------------------------------------
  // Values after reset
  // ----------------------------------------------------------------
  localparam logic [2:0] MODE_SEL_RST = 3'h7;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'h00;

  // ----------------------------------------------------------------
  // Operating modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SPISMP_M_DIV4 = 3'b000,
    SPISMP_M_DIV16 = 3'b001,
    SPISMP_M_DIV64 = 3'b010,
    SPISMP_M_SUB = 3'b011,
    SPISMP_M_TIMER = 3'b100,
    SPISMP_SLAVE = 3'b101,
    SPISMP_I2C = 3'b110,
    SPISMP_UNUSED = 3'b111
  } spismp_mode_t;

  // ----------------------------------------------------------------
  // Timing: serial clock period and half period in system cycles
  // ----------------------------------------------------------------
  localparam int DIV4_RATIO = 4;
  localparam int DIV16_RATIO = 16;
  localparam int DIV64_RATIO = 64;
  localparam logic [5:0] HALF_DIV4 = 6'(DIV4_RATIO / 2);
  localparam logic [5:0] HALF_DIV16 = 6'(DIV16_RATIO / 2);
  localparam logic [5:0] HALF_DIV64 = 6'(DIV64_RATIO / 2);
  localparam logic [3:0] LAST_EDGE = 4'hF; // Sixteen edges, eight bits

endpackage : spismp_pkg

//--- spismp_sync.sv
`timescale 1ns/100ps

module spismp_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Asynchronous levels in, synchronised levels out
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } spismp_sync_t;

  spismp_sync_t s;
  spismp_sync_t next_s;

  // First stage feeds only the second stage
  always_comb begin
    next_s.meta = async_i;
    next_s.stable = s.meta;
  end

  // Both stages
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= {RST_VAL, RST_VAL};
    end else begin
      s <= next_s;
    end
  end

  assign sync_o = s.stable;

endmodule : spismp_sync

//--- testbench.sv
`timescale 1ns/100ps

module testbench;
  // ------------------------------------------------
  // Signals
  // ------------------------------------------------
  typedef struct packed {
    logic [2:0] mode;
    logic [2:0] ctl;
    logic [7:0] tx;
    logic [7:0] ptx;
    logic [7:0] exp_rx;
    logic [7:0] exp_rd;
    logic [9:0] len;
  } spismp_row_t;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [1:0] addr_i = 2'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic sub_clk_i = 1'b0;
  logic timer_match_i = 1'b0;
  logic [1:0] tcnt = 2'h0;
  logic [7:0] rdata_o;
  logic sck_o, sck_oe_o, sdo_o, sdo_oe_o, scs_n_o, scs_oe_o, spi_event_o;
  logic ext_m = 1'b0;
  logic m_sck = 1'b1;
  logic m_scs_n = 1'b1;
  logic m_sdi = 1'b0;
  logic peer_sdi;
  logic [2:0] p_ctl = 3'h0;
  logic [7:0] p_tx = 8'h00;
  logic [7:0] prx;
  logic [7:0] got;
  int mismatches = 0;
  int samples_checked = 0;
  int evt_cnt = 0;
  int e0;
  spismp_row_t r;
  spismp_row_t rows [5] = '{
    {3'h0, 3'h1, 8'h96, 8'h3C, 8'h96, 8'h3C, 10'h020},
    {3'h1, 3'h6, 8'h81, 8'h7E, 8'h81, 8'h7E, 10'h080},
    {3'h2, 3'h3, 8'h5A, 8'hC3, 8'h5A, 8'hC3, 10'h200},
    {3'h3, 3'h4, 8'h01, 8'h80, 8'h01, 8'h80, 10'h040},
    {3'h4, 3'h0, 8'hF0, 8'h0F, 8'hF0, 8'h0F, 10'h040}};
  wire sck_w = sck_oe_o ? sck_o : m_sck;
  wire scs_w = scs_oe_o ? scs_n_o : m_scs_n;
  wire sdi_w = ext_m ? m_sdi : peer_sdi;

  // Clocks and timer pulses
  always #50 clk_i = ~clk_i;
  always #400 sub_clk_i = ~sub_clk_i;
  always @(posedge clk_i) begin
    tcnt <= tcnt + 2'h1;
    timer_match_i <= (tcnt == 2'h0);
    if (spi_event_o === 1'b1) evt_cnt <= evt_cnt + 1;
  end

  spismp_core dut_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .sub_clk_i(sub_clk_i),
    .timer_match_i(timer_match_i), .sck_i(sck_w), .sck_o(sck_o), .sck_oe_o(sck_oe_o),
    .sdi_i(sdi_w), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .scs_n_i(scs_w), .scs_n_o(scs_n_o),
    .scs_oe_o(scs_oe_o), .spi_event_o(spi_event_o));
  spismp_peer peer_u (.clk_i(clk_i), .sck_i(sck_w), .sdo_i(sdo_o), .scs_n_i(scs_w),
    .sdi_o(peer_sdi), .ctl_i(p_ctl), .tx_i(p_tx), .rx_o(prx));

  // ------------------------------------------------
  // Tasks
  // ------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    @(posedge clk_i);
  endtask : wr

  task automatic rdchk(input logic [1:0] a, input logic [7:0] exp, input string nm);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    chk(nm, rdata_o, exp);
    @(posedge clk_i);
  endtask : rdchk

  task automatic xfer_wait(input logic [9:0] len);
    int n;
    n = 0;
    e0 = evt_cnt;
    while (evt_cnt == e0 && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    repeat (3) @(posedge clk_i);
    chk("events", 8'(evt_cnt - e0), 8'h01);
    chk("length", {7'h0, (n + 12 > int'(len)) && (n < int'(len) + 12)}, 8'h01);
  endtask : xfer_wait

  // External master: idle high, launch on falling, capture on rising, MSB first
  task automatic mstr(input int edges, input logic [7:0] din);
    m_scs_n <= 1'b0;
    repeat (8) @(posedge clk_i);
    for (int i = 0; i < edges; i++) begin
      if (i % 2 == 0) m_sdi <= din[7 - i / 2];
      else got[7 - i / 2] = sdo_o;
      m_sck <= ~m_sck;
      repeat (8) @(posedge clk_i);
    end
    m_scs_n <= 1'b1;
    repeat (8) @(posedge clk_i);
  endtask : mstr

  task automatic do_reset;
    arst_n_i <= 1'b0;
    repeat (12) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
  endtask : do_reset

  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : results

  // ------------------------------------------------
  // Sequence
  // ------------------------------------------------
  initial begin
    #(100 * 20000);
    mismatches++;
    results();
  end

  initial begin
    do_reset();
    // Master transfers over every clock source, with a colliding write
    foreach (rows[k]) begin
      r = rows[k];
      p_ctl <= r.ctl;
      p_tx <= r.ptx;
      wr(spismp_pkg::ADDR_CFG, {2'h0, r.ctl, 3'h4});
      wr(spismp_pkg::ADDR_MODE, {r.mode, 5'h02});
      rdchk(spismp_pkg::ADDR_MODE, {r.mode, 5'h02}, "mode");
      wr(spismp_pkg::ADDR_DATA, r.tx);
      chk("scs_n", {6'h0, sdo_oe_o, scs_w}, 8'h02);
      wr(spismp_pkg::ADDR_DATA, 8'hFF);
      xfer_wait(r.len);
      chk("sck idle", {7'h0, sck_w}, {7'h0, ~r.ctl[2]});
      chk("peer rx", prx, r.exp_rx);
      rdchk(spismp_pkg::ADDR_DATA, r.exp_rd, "data");
      rdchk(spismp_pkg::ADDR_CFG, {2'h0, r.ctl, 3'h7}, "cfg");
    end
    // I2C and unused modes run no SPI transfer
    for (int m = 6; m < 8; m++) begin
      e0 = evt_cnt;
      wr(spismp_pkg::ADDR_MODE, {3'(m), 5'h02});
      wr(spismp_pkg::ADDR_DATA, 8'h55);
      repeat (40) @(posedge clk_i);
      chk("no sck", {6'h0, sck_oe_o, 8'(evt_cnt - e0) != 8'h00}, 8'h00);
    end
    // Disable releases pins; enable keeps settings
    wr(spismp_pkg::ADDR_CFG, 8'hC4);
    wr(spismp_pkg::ADDR_MODE, 8'h00);
    chk("oe off", {5'h0, sck_oe_o, sdo_oe_o, scs_oe_o}, 8'h00);
    wr(spismp_pkg::ADDR_MODE, 8'h02);
    rdchk(spismp_pkg::ADDR_CFG, 8'hC4, "cfg kept");
    // Slave: full byte, then deselect mid-byte
    wr(spismp_pkg::ADDR_CFG, 8'h0C);
    wr(spismp_pkg::ADDR_MODE, 8'hA2);
    ext_m <= 1'b1;
    chk("slave sck", {7'h0, sck_oe_o}, 8'h00);
    wr(spismp_pkg::ADDR_DATA, 8'hA5);
    e0 = evt_cnt;
    mstr(16, 8'h3C);
    chk("slave out", got, 8'hA5);
    rdchk(spismp_pkg::ADDR_DATA, 8'h3C, "slave in");
    rdchk(spismp_pkg::ADDR_CFG, 8'h0D, "slave trf");
    wr(spismp_pkg::ADDR_CFG, 8'h0C);
    mstr(6, 8'h00);
    rdchk(spismp_pkg::ADDR_MODE, 8'hA3, "icf");
    rdchk(spismp_pkg::ADDR_CFG, 8'h0D, "icf trf");
    chk("slave events", 8'(evt_cnt - e0), 8'h02);
    // Second reset, unimplemented bit, software incomplete flag
    ext_m <= 1'b0;
    do_reset();
    rdchk(spismp_pkg::ADDR_MODE, 8'hE0, "mode rst");
    wr(spismp_pkg::ADDR_MODE, 8'hFF);
    rdchk(spismp_pkg::ADDR_MODE, 8'hEF, "bit4");
    rdchk(spismp_pkg::ADDR_CFG, 8'h00, "sw icf");
    rdchk(2'h3, 8'h00, "unmapped");
    results();
  end
endmodule : testbench
